// ### hw/rtx_core.sv
// register transfer and exchange executor with its programmer-visible register set
// assumes requests and irq_pending come from logic on clk; one request in flight at a time
// Functional notes
// - stack to index ops load bank:index with stack bank:pointer plus 2, 2 cycles
// - index to stack ops load stack bank:pointer with index bank:index minus 2
// - index to index ops copy the whole 20-bit bank and pointer, 2 cycles
// - bank reads put the 4-bit bank in b low nibble, clear upper nibble
// - wait op is decoded and takes 8 cycles if irq_pending is set, else halts until it is, flags untouched
// - swap d with x, y, z or e, and a with b, 2 cycles, flags untouched
// - swap e with x, y or z, 2 cycles, flags untouched
// - result flag update changes only flag bits 15 to 4, program bank kept
// - branches take one count when taken, another when not taken
// - flag restore replaces all 16 flag bits with the popped copy
// - bank restore replaces only the program bank, other flag bits kept
`timescale 1ns/1ps
`include "rtx_defs.svh"
module rtx_core #(
	parameter logic [7:0] BR_TAKEN_CYC = 8'h04,
	parameter logic [7:0] BR_NOT_CYC = 8'h02
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request port
	input wire logic req_valid,
	input wire rtx_pkg::rtx_req_t req_kind,
	input wire logic [15:0] req_opcode,
	input wire logic [15:0] req_data,
	input wire rtx_pkg::rtx_sel_t req_sel,
	input wire logic req_taken,
	output logic req_ready,
	// completion and wait status
	input wire logic irq_pending,
	output logic done,
	output logic illegal,
	output logic exc_req,
	output logic waiting,
	// register set
	output logic [7:0] acc_a,
	output logic [7:0] acc_b,
	output logic [15:0] acc_e,
	output logic [15:0] index_x,
	output logic [15:0] index_y,
	output logic [15:0] index_z,
	output logic [3:0] index_x_bank,
	output logic [3:0] index_y_bank,
	output logic [3:0] index_z_bank,
	output logic [15:0] stack_pointer,
	output logic [3:0] stack_bank,
	output logic [15:0] condition_flags
);
	rtx_dec_if dif ();
	rtx_decode u_dec (.d(dif));
	assign dif.opcode = req_opcode;

	rtx_pkg::rtx_state_t state_r, state_nxt;
	rtx_pkg::rtx_op_t op_r, op_nxt, req_op;
	rtx_pkg::rtx_sel_t sel_r, sel_nxt;
	logic [7:0] cnt_r, cnt_nxt, req_cyc;
	logic [15:0] data_r, data_nxt;
	logic ready_r, ready_nxt, done_r, done_nxt, ill_r, ill_nxt;
	logic exc_r, exc_nxt, wait_r, wait_nxt;
	logic [7:0] a_r, a_nxt, b_r, b_nxt;
	logic [15:0] e_r, e_nxt, ix_r, ix_nxt, iy_r, iy_nxt, iz_r, iz_nxt;
	logic [15:0] sp_r, sp_nxt, flg_r, flg_nxt;
	logic [3:0] xb_r, xb_nxt, yb_r, yb_nxt, zb_r, zb_nxt, sb_r, sb_nxt;
	logic accept, exec;
	logic [19:0] s20, x20, y20, z20;
	logic [15:0] d16;

	assign accept = req_valid && ready_r;
	assign exec = (state_r == rtx_pkg::ST_RUN) && (cnt_r <= 8'h01);
	assign s20 = {sb_r, sp_r};
	assign x20 = {xb_r, ix_r};
	assign y20 = {yb_r, iy_r};
	assign z20 = {zb_r, iz_r};
	assign d16 = {a_r, b_r};

	// request kind to operation and length; flag and branch kinds bypass the decoder
	always_comb begin
		req_op = rtx_pkg::OP_ILLEGAL;
		req_cyc = `RTX_CYC_XFER;
		case (req_kind)
			rtx_pkg::REQ_OPCODE: begin
				req_op = dif.op;
				req_cyc = dif.cycles;
			end
			rtx_pkg::REQ_FLAG_RESULT: begin
				req_op = rtx_pkg::OP_FLAG_RES;
				req_cyc = `RTX_CYC_FLAG;
			end
			rtx_pkg::REQ_FLAG_POP: begin
				req_op = rtx_pkg::OP_FLAG_POP;
				req_cyc = `RTX_CYC_FLAG;
			end
			rtx_pkg::REQ_BANK_POP: begin
				req_op = rtx_pkg::OP_BANK_POP;
				req_cyc = `RTX_CYC_FLAG;
			end
			rtx_pkg::REQ_BRANCH: begin
				req_op = rtx_pkg::OP_BRANCH;
				req_cyc = req_taken ? BR_TAKEN_CYC : BR_NOT_CYC;
			end
			rtx_pkg::REQ_LOAD: begin
				req_op = rtx_pkg::OP_LOAD;
				req_cyc = `RTX_CYC_LOAD;
			end
			default: ;
		endcase
	end

	// sequencer: counts the cycles of the held operation; a count of 1 still ends at 2, a count of 0 wraps to 256
	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		sel_nxt = sel_r;
		data_nxt = data_r;
		cnt_nxt = cnt_r;
		ready_nxt = ready_r;
		done_nxt = 1'b0;
		ill_nxt = 1'b0;
		exc_nxt = 1'b0;
		wait_nxt = wait_r;
		case (state_r)
			rtx_pkg::ST_IDLE: begin
				if (accept) begin
					op_nxt = req_op;
					sel_nxt = req_sel;
					data_nxt = req_data;
					cnt_nxt = req_cyc - 8'h01;
					ready_nxt = 1'b0;
					state_nxt = rtx_pkg::ST_RUN;
				end
			end
			rtx_pkg::ST_RUN: begin
				if (cnt_r > 8'h01) begin
					cnt_nxt = cnt_r - 8'h01;
				end else if (op_r == rtx_pkg::OP_IDLE_IRQ && !irq_pending) begin
					state_nxt = rtx_pkg::ST_HALT;
					wait_nxt = 1'b1;
				end else begin
					state_nxt = rtx_pkg::ST_IDLE;
					ready_nxt = 1'b1;
					done_nxt = 1'b1;
					ill_nxt = (op_r == rtx_pkg::OP_ILLEGAL);
					exc_nxt = (op_r == rtx_pkg::OP_IDLE_IRQ);
				end
			end
			rtx_pkg::ST_HALT: begin
				// fetch stays stalled; the pending request hands over to exception entry
				if (irq_pending) begin
					state_nxt = rtx_pkg::ST_IDLE;
					ready_nxt = 1'b1;
					done_nxt = 1'b1;
					exc_nxt = 1'b1;
					wait_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = rtx_pkg::ST_IDLE;
				ready_nxt = 1'b1;
				wait_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= rtx_pkg::ST_IDLE;
			op_r <= rtx_pkg::OP_ILLEGAL;
			sel_r <= rtx_pkg::SEL_A;
			data_r <= `RTX_RST_WORD;
			cnt_r <= `RTX_RST_BYTE;
			ready_r <= 1'b1;
			done_r <= 1'b0;
			ill_r <= 1'b0;
			exc_r <= 1'b0;
			wait_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			sel_r <= sel_nxt;
			data_r <= data_nxt;
			cnt_r <= cnt_nxt;
			ready_r <= ready_nxt;
			done_r <= done_nxt;
			ill_r <= ill_nxt;
			exc_r <= exc_nxt;
			wait_r <= wait_nxt;
		end
	end

	// register effects land on the last cycle; transfers never touch the flags word
	always_comb begin
		a_nxt = a_r;
		b_nxt = b_r;
		e_nxt = e_r;
		{xb_nxt, ix_nxt} = x20;
		{yb_nxt, iy_nxt} = y20;
		{zb_nxt, iz_nxt} = z20;
		{sb_nxt, sp_nxt} = s20;
		flg_nxt = flg_r;
		if (exec) begin
			case (op_r)
				rtx_pkg::OP_STACK_TO_X: {xb_nxt, ix_nxt} = s20 + `RTX_STACK_ADJ;
				rtx_pkg::OP_STACK_TO_Y: {yb_nxt, iy_nxt} = s20 + `RTX_STACK_ADJ;
				rtx_pkg::OP_STACK_TO_Z: {zb_nxt, iz_nxt} = s20 + `RTX_STACK_ADJ;
				rtx_pkg::OP_X_TO_STACK: {sb_nxt, sp_nxt} = x20 - `RTX_STACK_ADJ;
				rtx_pkg::OP_Y_TO_STACK: {sb_nxt, sp_nxt} = y20 - `RTX_STACK_ADJ;
				rtx_pkg::OP_Z_TO_STACK: {sb_nxt, sp_nxt} = z20 - `RTX_STACK_ADJ;
				rtx_pkg::OP_X_COPY_Y: {yb_nxt, iy_nxt} = x20;
				rtx_pkg::OP_X_COPY_Z: {zb_nxt, iz_nxt} = x20;
				rtx_pkg::OP_Y_COPY_X: {xb_nxt, ix_nxt} = y20;
				rtx_pkg::OP_Y_COPY_Z: {zb_nxt, iz_nxt} = y20;
				rtx_pkg::OP_Z_COPY_X: {xb_nxt, ix_nxt} = z20;
				rtx_pkg::OP_Z_COPY_Y: {yb_nxt, iy_nxt} = z20;
				rtx_pkg::OP_X_BANK_RD: b_nxt = {4'h0, xb_r};
				rtx_pkg::OP_Y_BANK_RD: b_nxt = {4'h0, yb_r};
				rtx_pkg::OP_Z_BANK_RD: b_nxt = {4'h0, zb_r};
				rtx_pkg::OP_SWAP_AB: begin
					a_nxt = b_r;
					b_nxt = a_r;
				end
				rtx_pkg::OP_SWAP_DE: begin
					{a_nxt, b_nxt} = e_r;
					e_nxt = d16;
				end
				rtx_pkg::OP_SWAP_DX: begin
					{a_nxt, b_nxt} = ix_r;
					ix_nxt = d16;
				end
				rtx_pkg::OP_SWAP_DY: begin
					{a_nxt, b_nxt} = iy_r;
					iy_nxt = d16;
				end
				rtx_pkg::OP_SWAP_DZ: begin
					{a_nxt, b_nxt} = iz_r;
					iz_nxt = d16;
				end
				rtx_pkg::OP_SWAP_EX: begin
					e_nxt = ix_r;
					ix_nxt = e_r;
				end
				rtx_pkg::OP_SWAP_EY: begin
					e_nxt = iy_r;
					iy_nxt = e_r;
				end
				rtx_pkg::OP_SWAP_EZ: begin
					e_nxt = iz_r;
					iz_nxt = e_r;
				end
				rtx_pkg::OP_FLAG_RES: flg_nxt = {data_r[15:`RTX_UPD_LSB], flg_r[`RTX_PBANK_MSB:0]};
				rtx_pkg::OP_FLAG_POP: flg_nxt = data_r;
				rtx_pkg::OP_BANK_POP: flg_nxt = {flg_r[15:`RTX_UPD_LSB], data_r[`RTX_PBANK_MSB:0]};
				rtx_pkg::OP_LOAD: begin
					// preset path so software-visible state can be seeded before a transfer
					case (sel_r)
						rtx_pkg::SEL_A: a_nxt = data_r[7:0];
						rtx_pkg::SEL_B: b_nxt = data_r[7:0];
						rtx_pkg::SEL_E: e_nxt = data_r;
						rtx_pkg::SEL_X: ix_nxt = data_r;
						rtx_pkg::SEL_Y: iy_nxt = data_r;
						rtx_pkg::SEL_Z: iz_nxt = data_r;
						rtx_pkg::SEL_XBANK: xb_nxt = data_r[3:0];
						rtx_pkg::SEL_YBANK: yb_nxt = data_r[3:0];
						rtx_pkg::SEL_ZBANK: zb_nxt = data_r[3:0];
						rtx_pkg::SEL_SP: sp_nxt = data_r;
						rtx_pkg::SEL_SBANK: sb_nxt = data_r[3:0];
						rtx_pkg::SEL_FLAGS: flg_nxt = data_r;
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			a_r <= `RTX_RST_BYTE;
			b_r <= `RTX_RST_BYTE;
			{e_r, ix_r, iy_r, iz_r, sp_r, flg_r} <= {6{`RTX_RST_WORD}};
			{xb_r, yb_r, zb_r, sb_r} <= {4{`RTX_RST_BANK}};
		end else begin
			a_r <= a_nxt;
			b_r <= b_nxt;
			{e_r, ix_r, iy_r, iz_r, sp_r, flg_r} <= {e_nxt, ix_nxt, iy_nxt, iz_nxt, sp_nxt, flg_nxt};
			{xb_r, yb_r, zb_r, sb_r} <= {xb_nxt, yb_nxt, zb_nxt, sb_nxt};
		end
	end

	// outputs straight from flops
	assign req_ready = ready_r;
	assign done = done_r;
	assign illegal = ill_r;
	assign exc_req = exc_r;
	assign waiting = wait_r;
	assign {acc_a, acc_b, acc_e} = {a_r, b_r, e_r};
	assign {index_x, index_y, index_z} = {ix_r, iy_r, iz_r};
	assign {index_x_bank, index_y_bank, index_z_bank} = {xb_r, yb_r, zb_r};
	assign {stack_pointer, stack_bank, condition_flags} = {sp_r, sb_r, flg_r};

	// checks; done_r rises on the commit edge, so one edge later $past gives the old values
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_xfer_start;
		accept && req_kind == rtx_pkg::REQ_OPCODE && dif.legal && dif.op != rtx_pkg::OP_IDLE_IRQ;
	endsequence
	sequence s_wait_start;
		accept && req_kind == rtx_pkg::REQ_OPCODE && dif.op == rtx_pkg::OP_IDLE_IRQ;
	endsequence
	sequence s_two_cycle_end;
		!ready_r ##1 (done_r && ready_r);
	endsequence
	a_xfer_two_cyc: assert property (s_xfer_start |=> s_two_cycle_end)
		else $error("transfer did not finish in two cycles");
	a_stack_to_x: assert property (done_r && op_r == rtx_pkg::OP_STACK_TO_X |->
		x20 == $past(s20) + `RTX_STACK_ADJ)
		else $error("stack to x result wrong");
	a_x_to_stack: assert property (done_r && op_r == rtx_pkg::OP_X_TO_STACK |->
		s20 == $past(x20) - `RTX_STACK_ADJ)
		else $error("x to stack result wrong");
	a_z_copy_y: assert property (done_r && op_r == rtx_pkg::OP_Z_COPY_Y |->
		y20 == $past(z20) && z20 == $past(z20))
		else $error("z copy to y wrong");
	a_bank_read_x: assert property (done_r && op_r == rtx_pkg::OP_X_BANK_RD |->
		b_r == {4'h0, $past(xb_r)} && a_r == $past(a_r))
		else $error("x bank read wrong");
	a_wait_length: assert property (s_wait_start |=> !ready_r [*7])
		else $error("wait ended before eight cycles");
	a_swap_d_e: assert property (done_r && op_r == rtx_pkg::OP_SWAP_DE |->
		e_r == $past(d16) && d16 == $past(e_r))
		else $error("d e swap wrong");
	a_swap_e_x: assert property (done_r && op_r == rtx_pkg::OP_SWAP_EX |->
		e_r == $past(ix_r) && ix_r == $past(e_r))
		else $error("e x swap wrong");
	a_flags_kept: assert property (done_r && op_r != rtx_pkg::OP_FLAG_RES &&
		op_r != rtx_pkg::OP_FLAG_POP && op_r != rtx_pkg::OP_BANK_POP &&
		op_r != rtx_pkg::OP_LOAD |-> $stable(flg_r))
		else $error("flags changed by a transfer");
	a_flags_result: assert property (done_r && op_r == rtx_pkg::OP_FLAG_RES |->
		flg_r == {data_r[15:4], $past(flg_r[3:0])})
		else $error("result flag update wrong");
	a_flags_pop: assert property (done_r && op_r == rtx_pkg::OP_FLAG_POP |->
		flg_r == data_r)
		else $error("flag restore wrong");
	a_bank_pop: assert property (done_r && op_r == rtx_pkg::OP_BANK_POP |->
		flg_r == {$past(flg_r[15:4]), data_r[3:0]})
		else $error("bank restore wrong");
	a_halt_holds: assert property (state_r == rtx_pkg::ST_HALT && !irq_pending |=>
		state_r == rtx_pkg::ST_HALT && !ready_r && wait_r)
		else $error("wait left without interrupt");
	a_halt_wakes: assert property (state_r == rtx_pkg::ST_HALT && irq_pending |=>
		exc_r && done_r && ready_r && !wait_r)
		else $error("wait did not wake on interrupt");
endmodule : rtx_core

// ### pkg/rtx_defs.svh
// constants for the register transfer and exchange executor: opcodes, cycle counts, fields
// assumes it is included by bare name, once per compilation unit thanks to the guard
`ifndef RTX_DEFS_SVH
`define RTX_DEFS_SVH
// stack to index, index to stack
`define RTX_OPC_STACK_TO_X 16'h274F
`define RTX_OPC_STACK_TO_Y 16'h275F
`define RTX_OPC_STACK_TO_Z 16'h276F
`define RTX_OPC_X_TO_STACK 16'h374E
`define RTX_OPC_Y_TO_STACK 16'h375E
`define RTX_OPC_Z_TO_STACK 16'h376E
// index to index copies
`define RTX_OPC_X_COPY_Y 16'h275C
`define RTX_OPC_X_COPY_Z 16'h276C
`define RTX_OPC_Y_COPY_X 16'h274D
`define RTX_OPC_Y_COPY_Z 16'h276D
`define RTX_OPC_Z_COPY_X 16'h274E
`define RTX_OPC_Z_COPY_Y 16'h275E
// bank reads into accumulator b
`define RTX_OPC_X_BANK_RD 16'h37AC
`define RTX_OPC_Y_BANK_RD 16'h37AD
`define RTX_OPC_Z_BANK_RD 16'h37AE
// wait and exchanges
`define RTX_OPC_IDLE_IRQ 16'h27F3
`define RTX_OPC_SWAP_AB 16'h371A
`define RTX_OPC_SWAP_DE 16'h277A
`define RTX_OPC_SWAP_DX 16'h37CC
`define RTX_OPC_SWAP_DY 16'h37DC
`define RTX_OPC_SWAP_DZ 16'h37EC
`define RTX_OPC_SWAP_EX 16'h374C
`define RTX_OPC_SWAP_EY 16'h375C
`define RTX_OPC_SWAP_EZ 16'h376C
// cycle counts
`define RTX_CYC_XFER 8'h02
`define RTX_CYC_WAIT 8'h08
`define RTX_CYC_FLAG 8'h02
`define RTX_CYC_LOAD 8'h02
// stack adjust and flag fields
`define RTX_STACK_ADJ 20'h00002
`define RTX_PBANK_MSB 3
`define RTX_UPD_LSB 4
// reset values
`define RTX_RST_WORD 16'h0000
`define RTX_RST_BANK 4'h0
`define RTX_RST_BYTE 8'h00
`endif

// ### pkg/rtx_pkg.sv
// types shared by the executor and its opcode decoder
// assumes nothing beyond a SystemVerilog compiler
package rtx_pkg;
	typedef enum logic [4:0] {
		OP_ILLEGAL, OP_STACK_TO_X, OP_STACK_TO_Y, OP_STACK_TO_Z,
		OP_X_TO_STACK, OP_Y_TO_STACK, OP_Z_TO_STACK,
		OP_X_COPY_Y, OP_X_COPY_Z, OP_Y_COPY_X, OP_Y_COPY_Z, OP_Z_COPY_X, OP_Z_COPY_Y,
		OP_X_BANK_RD, OP_Y_BANK_RD, OP_Z_BANK_RD, OP_IDLE_IRQ,
		OP_SWAP_AB, OP_SWAP_DE, OP_SWAP_DX, OP_SWAP_DY, OP_SWAP_DZ,
		OP_SWAP_EX, OP_SWAP_EY, OP_SWAP_EZ,
		OP_FLAG_RES, OP_FLAG_POP, OP_BANK_POP, OP_BRANCH, OP_LOAD
	} rtx_op_t;
	typedef enum logic [2:0] {
		REQ_OPCODE, REQ_FLAG_RESULT, REQ_FLAG_POP, REQ_BANK_POP, REQ_BRANCH, REQ_LOAD
	} rtx_req_t;
	typedef enum logic [3:0] {
		SEL_A, SEL_B, SEL_E, SEL_X, SEL_Y, SEL_Z, SEL_XBANK, SEL_YBANK, SEL_ZBANK,
		SEL_SP, SEL_SBANK, SEL_FLAGS
	} rtx_sel_t;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT} rtx_state_t;
endpackage : rtx_pkg

// ### pkg/rtx_dec_if.sv
// carrier between the executor and its opcode decoder
// assumes rtx_pkg is compiled first
`timescale 1ns/1ps
interface rtx_dec_if;
	logic [15:0] opcode;
	rtx_pkg::rtx_op_t op;
	logic [7:0] cycles;
	logic legal;
	modport dec (input opcode, output op, output cycles, output legal);
	modport core (output opcode, input op, input cycles, input legal);
endinterface : rtx_dec_if

// ### hw/rtx_decode.sv
// opcode decoder: maps a 16-bit opcode to an operation and its cycle count
// assumes a purely combinational path; the executor registers the result on accept
`timescale 1ns/1ps
`include "rtx_defs.svh"
module rtx_decode (
	// decode carrier
	rtx_dec_if.dec d
);
	// unknown opcodes fall through to the illegal operation
	always_comb begin
		case (d.opcode)
			`RTX_OPC_STACK_TO_X: d.op = rtx_pkg::OP_STACK_TO_X;
			`RTX_OPC_STACK_TO_Y: d.op = rtx_pkg::OP_STACK_TO_Y;
			`RTX_OPC_STACK_TO_Z: d.op = rtx_pkg::OP_STACK_TO_Z;
			`RTX_OPC_X_TO_STACK: d.op = rtx_pkg::OP_X_TO_STACK;
			`RTX_OPC_Y_TO_STACK: d.op = rtx_pkg::OP_Y_TO_STACK;
			`RTX_OPC_Z_TO_STACK: d.op = rtx_pkg::OP_Z_TO_STACK;
			`RTX_OPC_X_COPY_Y: d.op = rtx_pkg::OP_X_COPY_Y;
			`RTX_OPC_X_COPY_Z: d.op = rtx_pkg::OP_X_COPY_Z;
			`RTX_OPC_Y_COPY_X: d.op = rtx_pkg::OP_Y_COPY_X;
			`RTX_OPC_Y_COPY_Z: d.op = rtx_pkg::OP_Y_COPY_Z;
			`RTX_OPC_Z_COPY_X: d.op = rtx_pkg::OP_Z_COPY_X;
			`RTX_OPC_Z_COPY_Y: d.op = rtx_pkg::OP_Z_COPY_Y;
			`RTX_OPC_X_BANK_RD: d.op = rtx_pkg::OP_X_BANK_RD;
			`RTX_OPC_Y_BANK_RD: d.op = rtx_pkg::OP_Y_BANK_RD;
			`RTX_OPC_Z_BANK_RD: d.op = rtx_pkg::OP_Z_BANK_RD;
			`RTX_OPC_IDLE_IRQ: d.op = rtx_pkg::OP_IDLE_IRQ;
			`RTX_OPC_SWAP_AB: d.op = rtx_pkg::OP_SWAP_AB;
			`RTX_OPC_SWAP_DE: d.op = rtx_pkg::OP_SWAP_DE;
			`RTX_OPC_SWAP_DX: d.op = rtx_pkg::OP_SWAP_DX;
			`RTX_OPC_SWAP_DY: d.op = rtx_pkg::OP_SWAP_DY;
			`RTX_OPC_SWAP_DZ: d.op = rtx_pkg::OP_SWAP_DZ;
			`RTX_OPC_SWAP_EX: d.op = rtx_pkg::OP_SWAP_EX;
			`RTX_OPC_SWAP_EY: d.op = rtx_pkg::OP_SWAP_EY;
			`RTX_OPC_SWAP_EZ: d.op = rtx_pkg::OP_SWAP_EZ;
			default: d.op = rtx_pkg::OP_ILLEGAL;
		endcase
	end

	// every decoded operation here is two cycles except the wait
	assign d.legal = (d.op != rtx_pkg::OP_ILLEGAL);
	assign d.cycles = (d.op == rtx_pkg::OP_IDLE_IRQ) ? `RTX_CYC_WAIT : `RTX_CYC_XFER;
endmodule : rtx_decode

// ### tb/rtx_core_bench.sv
// self-checking bench for the transfer and exchange executor
// assumes rtx_pkg, rtx_dec_if, rtx_decode and rtx_core are compiled first
`timescale 1ns/1ps
`include "rtx_defs.svh"
module rtx_core_bench;
	// design ports
	logic clk, rst_n, req_valid, req_taken, irq_pending;
	rtx_pkg::rtx_req_t req_kind;
	logic [15:0] req_opcode, req_data;
	rtx_pkg::rtx_sel_t req_sel;
	logic req_ready, done, illegal, exc_req, waiting;
	logic [7:0] acc_a, acc_b;
	logic [15:0] acc_e, index_x, index_y, index_z, stack_pointer, condition_flags;
	logic [3:0] index_x_bank, index_y_bank, index_z_bank, stack_bank;
	// bench state
	int bad_count = 0;
	int checked = 0;
	int ncyc, tick = 0;
	logic saw_ill, saw_exc;
	rtx_pkg::rtx_sel_t isel [3];
	rtx_pkg::rtx_sel_t ksel [3];

	rtx_core dut_u (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_kind(req_kind),
		.req_opcode(req_opcode), .req_data(req_data), .req_sel(req_sel),
		.req_taken(req_taken), .req_ready(req_ready), .irq_pending(irq_pending),
		.done(done), .illegal(illegal), .exc_req(exc_req), .waiting(waiting),
		.acc_a(acc_a), .acc_b(acc_b), .acc_e(acc_e), .index_x(index_x),
		.index_y(index_y), .index_z(index_z), .index_x_bank(index_x_bank),
		.index_y_bank(index_y_bank), .index_z_bank(index_z_bank),
		.stack_pointer(stack_pointer), .stack_bank(stack_bank),
		.condition_flags(condition_flags));

	// free-running clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic chk_cyc(input string nm, input int exp, input int got);
		checked++;
		if (got != exp) begin
			bad_count++;
			$display("Error %s expected %0d seen %0d", nm, exp, got);
		end
	endtask : chk_cyc

	// bank:pointer of index 0..2
	function automatic logic [19:0] idx(input int i);
		case (i)
			0: return {index_x_bank, index_x};
			1: return {index_y_bank, index_y};
			default: return {index_z_bank, index_z};
		endcase
	endfunction : idx

	// called at a falling edge with ready high; returns at the falling edge showing done
	task automatic issue(input rtx_pkg::rtx_req_t k, input logic [15:0] opc,
		input logic [15:0] dat, input rtx_pkg::rtx_sel_t s, input logic tk);
		int n;
		n = 0;
		req_valid = 1'b1;
		req_kind = k;
		req_opcode = opc;
		req_data = dat;
		req_sel = s;
		req_taken = tk;
		@(posedge clk);
		// valid drops once, so a following call may raise it at the same falling edge
		@(negedge clk);
		req_valid = 1'b0;
		n = 1;
		chk("req_ready", 20'h00000, {19'h0, req_ready});
		while (done !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		saw_ill = illegal;
		saw_exc = exc_req;
		ncyc = n;
	endtask : issue

	task automatic ld(input rtx_pkg::rtx_sel_t s, input logic [15:0] v);
		issue(rtx_pkg::REQ_LOAD, 16'h0000, v, s, 1'b0);
	endtask : ld

	task automatic op(input logic [15:0] opc);
		issue(rtx_pkg::REQ_OPCODE, opc, 16'h0000, rtx_pkg::SEL_A, 1'b0);
	endtask : op

	task automatic set_idx(input int i, input logic [19:0] v);
		ld(ksel[i], {12'h000, v[19:16]});
		ld(isel[i], v[15:0]);
	endtask : set_idx

	// 20-bit wrap: F:FFFF plus 2 lands on 0:0001
	task automatic t_stk2idx();
		logic [15:0] opc [3];
		opc = '{`RTX_OPC_STACK_TO_X, `RTX_OPC_STACK_TO_Y, `RTX_OPC_STACK_TO_Z};
		ld(rtx_pkg::SEL_FLAGS, 16'hA5C3);
		ld(rtx_pkg::SEL_SBANK, 16'h000F);
		ld(rtx_pkg::SEL_SP, 16'hFFFF);
		for (int i = 0; i < 3; i++) begin
			op(opc[i]);
			chk_cyc("cycles", 2, ncyc);
			chk("index", 20'h00001, idx(i));
		end
		chk("flags", 20'h0A5C3, {4'h0, condition_flags});
		$display("test stack to index finished");
	endtask : t_stk2idx

	task automatic t_idx2stk();
		logic [15:0] opc [3];
		logic [19:0] v [3];
		opc = '{`RTX_OPC_X_TO_STACK, `RTX_OPC_Y_TO_STACK, `RTX_OPC_Z_TO_STACK};
		v = '{20'h00001, 20'h30000, 20'h5ABCD};
		for (int i = 0; i < 3; i++) begin
			set_idx(i, v[i]);
			op(opc[i]);
			chk_cyc("cycles", 2, ncyc);
			chk("stack", v[i] - 20'h00002, {stack_bank, stack_pointer});
		end
		chk("flags", 20'h0A5C3, {4'h0, condition_flags});
		$display("test index to stack finished");
	endtask : t_idx2stk

	task automatic t_copy();
		logic [15:0] opc [6];
		int src [6];
		int dst [6];
		logic [19:0] iv [3];
		logic [19:0] e [3];
		opc = '{`RTX_OPC_X_COPY_Y, `RTX_OPC_X_COPY_Z, `RTX_OPC_Y_COPY_X,
			`RTX_OPC_Y_COPY_Z, `RTX_OPC_Z_COPY_X, `RTX_OPC_Z_COPY_Y};
		src = '{0, 0, 1, 1, 2, 2};
		dst = '{1, 2, 0, 2, 0, 1};
		iv = '{20'h1A001, 20'h2B002, 20'h3C003};
		for (int j = 0; j < 6; j++) begin
			for (int k = 0; k < 3; k++) begin
				set_idx(k, iv[k]);
			end
			e = iv;
			e[dst[j]] = iv[src[j]];
			op(opc[j]);
			chk_cyc("cycles", 2, ncyc);
			for (int k = 0; k < 3; k++) begin
				chk("index", e[k], idx(k));
			end
		end
		$display("test index copies finished");
	endtask : t_copy

	// upper nibble of b starts set so a missing clear shows
	task automatic t_bankrd();
		logic [15:0] opc [3];
		logic [3:0] bk [3];
		opc = '{`RTX_OPC_X_BANK_RD, `RTX_OPC_Y_BANK_RD, `RTX_OPC_Z_BANK_RD};
		bk = '{4'h9, 4'hA, 4'h6};
		for (int i = 0; i < 3; i++) begin
			ld(rtx_pkg::SEL_B, 16'h00FF);
			set_idx(i, {bk[i], 16'h4321});
			op(opc[i]);
			chk_cyc("cycles", 2, ncyc);
			chk("acc_b", {16'h0000, bk[i]}, {12'h000, acc_b});
		end
		$display("test bank reads finished");
	endtask : t_bankrd

	// chained swaps against a small register model; banks must stay put
	task automatic t_swap();
		logic [15:0] sw [8];
		logic [15:0] md, me, t;
		logic [15:0] mx [3];
		logic [3:0] mb [3];
		sw = '{`RTX_OPC_SWAP_AB, `RTX_OPC_SWAP_DE, `RTX_OPC_SWAP_DX, `RTX_OPC_SWAP_DY,
			`RTX_OPC_SWAP_DZ, `RTX_OPC_SWAP_EX, `RTX_OPC_SWAP_EY, `RTX_OPC_SWAP_EZ};
		md = 16'h1234;
		me = 16'h5678;
		mx = '{16'h9ABC, 16'hDEF0, 16'h1357};
		mb = '{4'h1, 4'h2, 4'h3};
		ld(rtx_pkg::SEL_A, 16'h0012);
		ld(rtx_pkg::SEL_B, 16'h0034);
		ld(rtx_pkg::SEL_E, me);
		for (int i = 0; i < 3; i++) begin
			set_idx(i, {mb[i], mx[i]});
		end
		for (int j = 0; j < 8; j++) begin
			op(sw[j]);
			chk_cyc("cycles", 2, ncyc);
			t = md;
			case (j)
				0: md = {t[7:0], t[15:8]};
				1: begin
					md = me;
					me = t;
				end
				2, 3, 4: begin
					md = mx[j - 2];
					mx[j - 2] = t;
				end
				default: begin
					t = me;
					me = mx[j - 5];
					mx[j - 5] = t;
				end
			endcase
			chk("acc_d", {4'h0, md}, {4'h0, acc_a, acc_b});
			chk("acc_e", {4'h0, me}, {4'h0, acc_e});
			for (int k = 0; k < 3; k++) begin
				chk("index", {mb[k], mx[k]}, idx(k));
			end
			chk("flags", 20'h0A5C3, {4'h0, condition_flags});
		end
		$display("test swaps finished");
	endtask : t_swap

	task automatic t_flags();
		ld(rtx_pkg::SEL_FLAGS, 16'hABC5);
		issue(rtx_pkg::REQ_FLAG_RESULT, 16'h0000, 16'h123E, rtx_pkg::SEL_A, 1'b0);
		chk("flags", 20'h01235, {4'h0, condition_flags});
		issue(rtx_pkg::REQ_FLAG_POP, 16'h0000, 16'h7E69, rtx_pkg::SEL_A, 1'b0);
		chk("flags", 20'h07E69, {4'h0, condition_flags});
		issue(rtx_pkg::REQ_BANK_POP, 16'h0000, 16'h0002, rtx_pkg::SEL_A, 1'b0);
		chk("flags", 20'h07E62, {4'h0, condition_flags});
		issue(rtx_pkg::REQ_BRANCH, 16'h0000, 16'h0000, rtx_pkg::SEL_A, 1'b1);
		chk_cyc("taken", 4, ncyc);
		issue(rtx_pkg::REQ_BRANCH, 16'h0000, 16'h0000, rtx_pkg::SEL_A, 1'b0);
		chk_cyc("not taken", 2, ncyc);
		$display("test flags and branches finished");
	endtask : t_flags

	// irq already pending ends at eight cycles; otherwise the core halts until it arrives
	task automatic t_wait();
		irq_pending = 1'b1;
		op(`RTX_OPC_IDLE_IRQ);
		chk_cyc("cycles", 8, ncyc);
		chk("exc_req", 20'h00001, {19'h0, saw_exc});
		irq_pending = 1'b0;
		fork
			op(`RTX_OPC_IDLE_IRQ);
			begin
				repeat (12) @(negedge clk);
				chk("waiting", 20'h00001, {19'h0, waiting});
				irq_pending = 1'b1;
			end
		join
		chk_cyc("cycles", 13, ncyc);
		chk("exc_req", 20'h00001, {19'h0, saw_exc});
		chk("waiting", 20'h00000, {19'h0, waiting});
		chk("flags", 20'h07E62, {4'h0, condition_flags});
		irq_pending = 1'b0;
		op(16'hFFFF);
		chk("illegal", 20'h00001, {19'h0, saw_ill});
		chk("flags", 20'h07E62, {4'h0, condition_flags});
		$display("test wait finished");
	endtask : t_wait

	task automatic summarize();
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		tick <= tick + 1;
		if (tick == 3000) begin
			bad_count++;
			summarize();
		end
	end

	// main sequence, inputs move on falling edges only
	initial begin
		isel = '{rtx_pkg::SEL_X, rtx_pkg::SEL_Y, rtx_pkg::SEL_Z};
		ksel = '{rtx_pkg::SEL_XBANK, rtx_pkg::SEL_YBANK, rtx_pkg::SEL_ZBANK};
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_kind = rtx_pkg::REQ_OPCODE;
		req_opcode = 16'h0000;
		req_data = 16'h0000;
		req_sel = rtx_pkg::SEL_A;
		req_taken = 1'b0;
		irq_pending = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_stk2idx();
		t_idx2stk();
		t_copy();
		t_bankrd();
		t_swap();
		t_flags();
		t_wait();
		summarize();
	end
endmodule : rtx_core_bench
